/* spd_pkg.sv */
package spd_pkg;

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // Page selection
   localparam logic [7:0] SPD_PAGE_SEL_ADDR = 8'ha7;
   localparam logic [7:0] SPD_PAGE_SEL_RESET = 8'h00;
   localparam logic [7:0] SPD_PAGE_0 = 8'h00;
   localparam logic [7:0] SPD_PAGE_F = 8'h0f;

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // Address space: direct addresses from this base up are special function registers
   localparam logic [7:0] SPD_SFR_BASE = 8'h80;
   // Bit addresses below the register space land in data memory bytes 0x20..0x2f
   localparam logic [3:0] SPD_BIT_RAM_HI = 4'h2;
   // Examples of decoded registers
   localparam logic [7:0] SPD_XIRQ_EN1_ADDR = 8'he6;
   localparam logic [7:0] SPD_CS_THR_HIGH_ADDR = 8'h97;
   localparam logic [7:0] SPD_CRC_SECT_CNT_ADDR = 8'h97;

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // Occupancy maps, one bit per address 0x80..0xff, bit 0 is 0x80.
   // Bytes run from row 0xf8 (first) down to row 0x80 (last).
   localparam logic [127:0] SPD_MAP_COMMON = {
      8'h81, 8'h01, 8'h81, 8'hc9, 8'h01, 8'h03, 8'h01, 8'h01,
      8'h01, 8'hcd, 8'h11, 8'h81, 8'h03, 8'h01, 8'hff, 8'h8f};
   localparam logic [127:0] SPD_MAP_PAGE0 = {
      8'h1e, 8'h18, 8'h1e, 8'h06, 8'h00, 8'h00, 8'h3c, 8'h7e,
      8'h68, 8'h00, 8'h26, 8'h0a, 8'hfc, 8'hfe, 8'h00, 8'h00};
   localparam logic [127:0] SPD_MAP_PAGEF = {
      8'h7e, 8'hfe, 8'h70, 8'h16, 8'h1e, 8'h74, 8'hc0, 8'hf2,
      8'hfe, 8'h20, 8'ha6, 8'h76, 8'h9c, 8'hfe, 8'h00, 8'h00};

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // Which register set a decoded access went to
   typedef enum logic [1:0] {
      SPD_BANK_COMMON,
      SPD_BANK_PAGE0,
      SPD_BANK_PAGEF
   } spd_bank_t;

   typedef enum logic {
      SPD_ST_IDLE,
      SPD_ST_RMW
   } spd_state_t;

endpackage

/* spd_addr_decode.sv */
`timescale 1ns/1ps

module spd_addr_decode
   import spd_pkg::*;
(
   input wire logic [7:0] i_addr,    // Byte address
   input wire logic [7:0] i_page,    // Current page
   output logic o_is_sfr,            // Address in register space
   output logic o_hit_common,        // Register present on all pages
   output logic o_hit_page0,         // Page 0 register
   output logic o_hit_pagef,         // Page F register
   output logic o_is_page_sel        // The page register itself
);

   wire [6:0] map_idx = i_addr[6:0];
   wire page_is_0 = (i_page == SPD_PAGE_0);
   wire page_is_f = (i_page == SPD_PAGE_F);

   assign o_is_sfr = (i_addr >= SPD_SFR_BASE);
   // All-page registers win regardless of the page value
   assign o_hit_common = o_is_sfr & SPD_MAP_COMMON[map_idx];
   assign o_hit_page0 = o_is_sfr & ~o_hit_common & page_is_0 & SPD_MAP_PAGE0[map_idx];
   assign o_hit_pagef = o_is_sfr & ~o_hit_common & page_is_f & SPD_MAP_PAGEF[map_idx];
   assign o_is_page_sel = (i_addr == SPD_PAGE_SEL_ADDR);

endmodule

/* spd_page_decoder.sv */
`timescale 1ns/1ps

// What this block does
// - Holds an 8-bit page select value
// - Core write replaces the current page
// - Read of page register returns page
// - Page register at 0xa7 on all pages
// - All-page registers decode regardless of page
// - Address 0x97: threshold high page 0, count page F
// - Undefined addresses reserved, no function given
// - Direct addresses 0x80..0xff go to registers
// - Addresses ending 0x0/0x8 allow bit access
module spd_page_decoder
   import spd_pkg::*;
(
   input wire logic i_sys_clk,                 // 10 MHz system clock
   input wire logic i_reset,                   // Synchronous reset, active high
   input wire logic i_ce,                      // Clock enable, freezes all state when low
   input wire logic i_rd,                      // Core read request
   input wire logic i_wr,                      // Core write request
   input wire logic i_bit,                     // Request is a single-bit access
   input wire logic [7:0] i_addr,              // Direct byte address or bit address
   input wire logic [7:0] i_wdata,             // Write byte, bit 0 for bit writes
   input wire logic [7:0] i_sfr_rdata,         // Byte from the selected register
   input wire logic [7:0] i_ram_rdata,         // Byte from data memory
   output logic o_busy,                        // Bit write in progress, requests refused
   output logic [7:0] o_page_sel,              // Current page
   output logic o_sfr_rd,                      // Register read strobe
   output logic o_sfr_wr,                      // Register write strobe
   output spd_pkg::spd_bank_t o_sfr_bank,      // Register set addressed
   output logic o_ram_rd,                      // Data memory read strobe
   output logic o_ram_wr,                      // Data memory write strobe
   output logic [7:0] o_tgt_addr,              // Byte address of the strobed target
   output logic [7:0] o_tgt_wdata,             // Byte to write to the target
   output logic o_rvalid,                      // Read data valid pulse
   output logic [7:0] o_rdata                  // Read data
);

   import spd_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // Registers

   spd_state_t state_reg, state_next;
   logic [7:0] register_page_select_reg, register_page_select_next;
   logic busy_reg, busy_next;
   logic sfr_rd_reg, sfr_rd_next;
   logic sfr_wr_reg, sfr_wr_next;
   spd_bank_t bank_reg, bank_next;
   logic ram_rd_reg, ram_rd_next;
   logic ram_wr_reg, ram_wr_next;
   logic [7:0] addr_reg, addr_next;
   logic [7:0] wdata_reg, wdata_next;
   logic bit_reg, bit_next;
   logic [2:0] bit_idx_reg, bit_idx_next;
   logic bit_val_reg, bit_val_next;
   logic ret_reg, ret_next;
   logic loc_reg, loc_next;
   logic [7:0] loc_data_reg, loc_data_next;
   logic rvalid_reg, rvalid_next;
   logic [7:0] rdata_reg, rdata_next;

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // Address decode

   wire is_sfr;
   wire hit_common;
   wire hit_page0;
   wire hit_pagef;
   wire is_page_sel;

   // A bit address from 0x80 up names a byte whose address ends in 0x0 or 0x8; lower ones name bytes 0x20..0x2f
   wire [7:0] sfr_bit_byte = {i_addr[7:3], 3'b000};
   wire [7:0] ram_bit_byte = {SPD_BIT_RAM_HI, i_addr[6:3]};
   wire [7:0] byte_addr = i_bit ? (i_addr[7] ? sfr_bit_byte : ram_bit_byte) : i_addr;

   spd_addr_decode u_decode (
      .i_addr(byte_addr),
      .i_page(register_page_select_reg),
      .o_is_sfr(is_sfr),
      .o_hit_common(hit_common),
      .o_hit_page0(hit_page0),
      .o_hit_pagef(hit_pagef),
      .o_is_page_sel(is_page_sel)
   );

   wire mapped = hit_common | hit_page0 | hit_pagef;
   // Page register is served here and never strobed outward
   wire to_sfr = is_sfr & mapped & ~is_page_sel;
   wire to_ram = ~is_sfr;
   // Nothing is defined at such an address, so nothing is strobed
   wire reserved = is_sfr & ~mapped;
   wire page_hit = is_sfr & is_page_sel;

   wire accept = i_ce & (state_reg == SPD_ST_IDLE) & (i_rd | i_wr);
   wire req_wr = i_wr;
   wire bit_wr = req_wr & i_bit;
   // A bit write first reads the byte, so it issues a read strobe
   wire want_rd = ~req_wr | bit_wr;
   wire page_wr = accept & req_wr & ~i_bit & page_hit;

   wire spd_bank_t dec_bank = hit_common ? SPD_BANK_COMMON : (hit_page0 ? SPD_BANK_PAGE0 : SPD_BANK_PAGEF);

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // Bit merge for read-modify-write and bit extract for reads

   wire [7:0] rmw_src = sfr_rd_reg ? i_sfr_rdata : i_ram_rdata;
   wire [7:0] rmw_byte;
   wire [7:0] ret_src = loc_reg ? loc_data_reg : (sfr_rd_reg ? i_sfr_rdata : i_ram_rdata);
   wire ret_bit = ret_src[bit_idx_reg];

   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1)
      begin : g_merge
         assign rmw_byte[g] = (bit_idx_reg == 3'(g)) ? bit_val_reg : rmw_src[g];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // Next-state logic

   always_comb
   begin
      state_next = state_reg;
      register_page_select_next = register_page_select_reg;
      busy_next = 1'b0;
      sfr_rd_next = 1'b0;
      sfr_wr_next = 1'b0;
      bank_next = bank_reg;
      ram_rd_next = 1'b0;
      ram_wr_next = 1'b0;
      addr_next = addr_reg;
      wdata_next = wdata_reg;
      bit_next = bit_reg;
      bit_idx_next = bit_idx_reg;
      bit_val_next = bit_val_reg;
      ret_next = 1'b0;
      loc_next = 1'b0;
      loc_data_next = loc_data_reg;
      rvalid_next = ret_reg;
      rdata_next = ret_reg ? (bit_reg ? {7'h00, ret_bit} : ret_src) : 8'h00;

      unique case (state_reg)
         SPD_ST_IDLE:
         begin
            if (accept)
            begin
               addr_next = byte_addr;
               bank_next = dec_bank;
               bit_next = i_bit;
               bit_idx_next = i_addr[2:0];
               bit_val_next = i_wdata[0];
               wdata_next = i_wdata;
               sfr_rd_next = to_sfr & want_rd;
               sfr_wr_next = to_sfr & req_wr & ~i_bit;
               ram_rd_next = to_ram & want_rd;
               ram_wr_next = to_ram & req_wr & ~i_bit;
               ret_next = ~req_wr;
               // Page register reads back the live page; reserved reads give zero
               loc_next = ~req_wr & (page_hit | reserved);
               loc_data_next = page_hit ? register_page_select_reg : 8'h00;
               if (page_wr)
               begin
                  register_page_select_next = i_wdata;
               end
               // Reserved or page-register bit writes have nothing to modify
               if (bit_wr & (to_sfr | to_ram))
               begin
                  state_next = SPD_ST_RMW;
                  busy_next = 1'b1;
               end
            end
         end
         SPD_ST_RMW:
         begin
            // Byte is read this cycle; write it back next cycle with one bit changed
            sfr_wr_next = sfr_rd_reg;
            ram_wr_next = ram_rd_reg;
            wdata_next = rmw_byte;
            state_next = SPD_ST_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // State

   always_ff @(posedge i_sys_clk)
   begin
      if (i_reset)
      begin
         state_reg <= SPD_ST_IDLE;
         register_page_select_reg <= SPD_PAGE_SEL_RESET;
         busy_reg <= 1'b0;
         sfr_rd_reg <= 1'b0;
         sfr_wr_reg <= 1'b0;
         bank_reg <= SPD_BANK_COMMON;
         ram_rd_reg <= 1'b0;
         ram_wr_reg <= 1'b0;
         addr_reg <= 8'h00;
         wdata_reg <= 8'h00;
         bit_reg <= 1'b0;
         bit_idx_reg <= 3'h0;
         bit_val_reg <= 1'b0;
         ret_reg <= 1'b0;
         loc_reg <= 1'b0;
         loc_data_reg <= 8'h00;
         rvalid_reg <= 1'b0;
         rdata_reg <= 8'h00;
      end
      else if (i_ce)
      begin
         state_reg <= state_next;
         register_page_select_reg <= register_page_select_next;
         busy_reg <= busy_next;
         sfr_rd_reg <= sfr_rd_next;
         sfr_wr_reg <= sfr_wr_next;
         bank_reg <= bank_next;
         ram_rd_reg <= ram_rd_next;
         ram_wr_reg <= ram_wr_next;
         addr_reg <= addr_next;
         wdata_reg <= wdata_next;
         bit_reg <= bit_next;
         bit_idx_reg <= bit_idx_next;
         bit_val_reg <= bit_val_next;
         ret_reg <= ret_next;
         loc_reg <= loc_next;
         loc_data_reg <= loc_data_next;
         rvalid_reg <= rvalid_next;
         rdata_reg <= rdata_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign o_busy = busy_reg;
   assign o_page_sel = register_page_select_reg;
   assign o_sfr_rd = sfr_rd_reg;
   assign o_sfr_wr = sfr_wr_reg;
   assign o_sfr_bank = bank_reg;
   assign o_ram_rd = ram_rd_reg;
   assign o_ram_wr = ram_wr_reg;
   assign o_tgt_addr = addr_reg;
   assign o_tgt_wdata = wdata_reg;
   assign o_rvalid = rvalid_reg;
   assign o_rdata = rdata_reg;

endmodule

/* spd_page_decoder_properties.sv */
`timescale 1ns/1ps
module spd_page_decoder_properties
   import spd_pkg::*;
(
   input wire logic i_sys_clk, // clock
   input wire logic i_reset, // reset
   input wire logic i_ce, // enable
   input wire logic i_rd, // read
   input wire logic i_wr, // write
   input wire logic i_bit, // bit access
   input wire logic [7:0] i_addr, // address
   input wire logic [7:0] i_wdata, // write byte
   input wire logic o_busy, // rmw
   input wire logic [7:0] o_page_sel, // page
   input wire logic o_sfr_rd, // reg read
   input wire logic o_sfr_wr, // reg write
   input wire spd_pkg::spd_bank_t o_sfr_bank, // bank
   input wire logic o_ram_rd, // ram read
   input wire logic o_ram_wr, // ram write
   input wire logic [7:0] o_tgt_addr, // target
   input wire logic o_rvalid, // valid
   input wire logic [7:0] o_rdata // data
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_reset);
   wire logic go = i_ce && !o_busy && !i_bit && (i_rd || i_wr);
   wire logic ps = i_addr == SPD_PAGE_SEL_ADDR;
   wire logic hc = i_addr[7] && !ps && SPD_MAP_COMMON[i_addr[6:0]];
   wire logic h0 = i_addr[7] && !ps && !hc && o_page_sel == SPD_PAGE_0 && SPD_MAP_PAGE0[i_addr[6:0]];
   wire logic hf = i_addr[7] && !ps && !hc && o_page_sel == SPD_PAGE_F && SPD_MAP_PAGEF[i_addr[6:0]];
   wire logic [3:0] bn = i_addr[6:3];
   ////////////////////////////////////////
   property p_page_write;
      go && i_wr && ps |=> o_page_sel == $past(i_wdata);
   endproperty
   a_page_write: assert property (p_page_write) else $error("page not written");
   // A reset edge also moves the page, so it excuses a change
   property p_page_hold;
      !$stable(o_page_sel) |-> $past(i_reset) || $past(go && i_wr && ps);
   endproperty
   a_page_hold: assert property (p_page_hold) else $error("page moved");
   property p_page_read;
      go && !i_wr && ps ##1 i_ce |=> o_rvalid && o_rdata == $past(o_page_sel);
   endproperty
   a_page_read: assert property (p_page_read) else $error("page readback");
   property p_common;
      go && hc |=> (o_sfr_rd || o_sfr_wr) && o_sfr_bank == SPD_BANK_COMMON && o_tgt_addr == $past(i_addr);
   endproperty
   a_common: assert property (p_common) else $error("all-page decode");
   property p_paged;
      go && (h0 || hf) |=> (o_sfr_rd || o_sfr_wr) && o_sfr_bank == ($past(h0) ? SPD_BANK_PAGE0 : SPD_BANK_PAGEF);
   endproperty
   a_paged: assert property (p_paged) else $error("paged decode");
   property p_reserved;
      go && i_addr[7] && !ps && !hc && !h0 && !hf |=> !(o_sfr_rd || o_sfr_wr || o_ram_rd || o_ram_wr);
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved strobed");
   property p_ram;
      go && !i_addr[7] |=> (o_ram_rd || o_ram_wr) && !o_sfr_rd && o_tgt_addr == $past(i_addr);
   endproperty
   a_ram: assert property (p_ram) else $error("memory route");
   property p_bit_ram;
      i_ce && !o_busy && i_bit && i_wr && !i_addr[7] ##1 i_ce |-> o_busy && o_ram_rd
         ##1 o_ram_wr && o_tgt_addr == {SPD_BIT_RAM_HI, $past(bn, 2)};
   endproperty
   a_bit_ram: assert property (p_bit_ram) else $error("bit write");
endmodule

bind spd_page_decoder spd_page_decoder_properties u_spd_page_decoder_properties (.i_sys_clk, .i_reset, .i_ce,
   .i_rd, .i_wr, .i_bit, .i_addr, .i_wdata, .o_busy, .o_page_sel, .o_sfr_rd, .o_sfr_wr, .o_sfr_bank, .o_ram_rd,
   .o_ram_wr, .o_tgt_addr, .o_rvalid, .o_rdata);

/* spd_target_model.sv */
`timescale 1ns/1ps
module spd_target_model
   import spd_pkg::*;
(
   input wire logic i_sfr_rd, // reg read strobe
   input wire logic i_ram_rd, // ram read strobe
   input wire spd_pkg::spd_bank_t i_bank, // register set
   input wire logic [7:0] i_addr, // target address
   output logic [7:0] o_sfr_rdata, // register byte
   output logic [7:0] o_ram_rdata // memory byte
);
   // Data follows address and bank, so a wrong target shows in the byte
   wire logic [7:0] reg_byte = {i_addr[3:0], i_addr[7:4]} ^ {6'h00, i_bank};
   // Scrambled outside a strobe: nothing holds the bytes valid then
   assign o_sfr_rdata = i_sfr_rd ? reg_byte : ~reg_byte;
   assign o_ram_rdata = i_ram_rd ? ~i_addr : i_addr;
endmodule

/* tb.sv */
`timescale 1ns/1ps
module tb;
   import spd_pkg::*;
   logic i_sys_clk = 1'h0;
   logic i_reset = 1'h1;
   logic i_ce = 1'h1;
   logic i_rd = 1'h0;
   logic i_wr = 1'h0;
   logic i_bit = 1'h0;
   logic [7:0] i_addr = 8'h00;
   logic [7:0] i_wdata = 8'h00;
   logic [7:0] i_sfr_rdata, i_ram_rdata, o_page_sel, o_tgt_addr, o_tgt_wdata, o_rdata;
   logic o_busy, o_sfr_rd, o_sfr_wr, o_ram_rd, o_ram_wr, o_rvalid;
   spd_bank_t o_sfr_bank;
   logic [7:0] q_rd[$];
   logic [21:0] q_st[$];
   logic [7:0] page = 8'h00;
   logic [7:0] pages[3] = '{8'h00, 8'h0f, 8'h5a};
   logic [31:0] seed = 32'hd03b;
   logic moved = 1'h0;
   int fails = 0;
   int comparisons = 0;
   wire logic [21:0] seen = {o_sfr_wr, o_sfr_rd, o_ram_wr, o_ram_rd, (o_sfr_rd | o_sfr_wr) ? 2'(o_sfr_bank) : 2'h0,
      o_tgt_addr, (o_sfr_wr | o_ram_wr) ? o_tgt_wdata : 8'h00};
   always #50 i_sys_clk = ~i_sys_clk;
   spd_page_decoder u_spd_page_decoder (.i_sys_clk, .i_reset, .i_ce, .i_rd, .i_wr, .i_bit, .i_addr, .i_wdata,
      .i_sfr_rdata, .i_ram_rdata, .o_busy, .o_page_sel, .o_sfr_rd, .o_sfr_wr, .o_sfr_bank, .o_ram_rd, .o_ram_wr,
      .o_tgt_addr, .o_tgt_wdata, .o_rvalid, .o_rdata);
   spd_target_model u_spd_target_model (.i_sfr_rd(o_sfr_rd), .i_ram_rd(o_ram_rd), .i_bank(o_sfr_bank),
      .i_addr(o_tgt_addr), .o_sfr_rdata(i_sfr_rdata), .o_ram_rdata(i_ram_rdata));
   ////////////////////////////////////////
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   task automatic chk_rd(input string what, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (got !== exp)
      begin
         fails++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task automatic chk_st(input string what, input logic [21:0] exp, input logic [21:0] got);
      comparisons++;
      if (got !== exp)
      begin
         fails++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d, fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Op is {enable, bit, write, read}; expectations are queued as the request is driven
   task automatic req(input logic [3:0] op, input logic [7:0] a, input logic [7:0] d);
      logic [7:0] b;
      logic [7:0] rb;
      logic [1:0] k;
      logic hit;
      logic live;
      b = !op[2] ? a : (a[7] ? {a[7:3], 3'h0} : {SPD_BIT_RAM_HI, a[6:3]});
      k = !b[7] || SPD_MAP_COMMON[b[6:0]] ? 2'h0 : (page == SPD_PAGE_0 ? 2'h1 : 2'h2);
      hit = !b[7] || SPD_MAP_COMMON[b[6:0]] || (page == SPD_PAGE_0 && SPD_MAP_PAGE0[b[6:0]])
         || (page == SPD_PAGE_F && SPD_MAP_PAGEF[b[6:0]]);
      rb = b[7] ? {b[3:0], b[7:4]} ^ {6'h00, k} : ~b;
      live = op[3] && (op[1] || op[0]);
      @(posedge i_sys_clk);
      {i_ce, i_bit, i_wr, i_rd} <= op;
      i_addr <= a;
      i_wdata <= d;
      if (live && !op[2] && b == SPD_PAGE_SEL_ADDR && op[1])
         page = d;
      else if (live && !op[2] && b == SPD_PAGE_SEL_ADDR)
         q_rd.push_back(page);
      else if (live && !hit && !op[1])
         q_rd.push_back(8'h00);
      else if (live && hit && !op[1])
      begin
         q_st.push_back({b[7] ? 4'h4 : 4'h1, k, b, 8'h00});
         q_rd.push_back(op[2] ? {7'h00, rb[a[2:0]]} : rb);
      end
      else if (live && hit && !op[2])
         q_st.push_back({b[7] ? 4'h8 : 4'h2, k, b, d});
      else if (live && hit)
      begin
         q_st.push_back({b[7] ? 4'h4 : 4'h1, k, b, 8'h00});
         rb[a[2:0]] = d[0];
         q_st.push_back({b[7] ? 4'h8 : 4'h2, k, b, rb});
      end
      // The cycle after a bit write to memory or a mapped register is refused, so it is left empty
      if (live && op[2] && op[1])
      begin
         @(posedge i_sys_clk);
         i_rd <= 1'h0;
         i_wr <= 1'h0;
      end
   endtask
   ////////////////////////////////////////
   always @(posedge i_sys_clk)
      moved <= i_ce && !i_reset;
   always @(negedge i_sys_clk)
   begin
      if (moved && o_rvalid === 1'h1)
         chk_rd("read data", q_rd.size() ? q_rd.pop_front() : 8'hxx, o_rdata);
      if (moved && (o_sfr_rd | o_sfr_wr | o_ram_rd | o_ram_wr) === 1'h1)
         chk_st("strobe", q_st.size() ? q_st.pop_front() : 22'hx, seen);
   end
   initial
   begin
      repeat (20000) @(posedge i_sys_clk);
      fails++;
      report_and_stop();
   end
   initial
   begin
      repeat (12) @(posedge i_sys_clk);
      i_reset <= 1'h0;
      req(4'h9, SPD_PAGE_SEL_ADDR, 8'h00);
      $display("test reset value done");
      for (int i = 0; i < 3; i++)
      begin
         req(4'ha, SPD_PAGE_SEL_ADDR, pages[i]);
         req(4'h9, SPD_PAGE_SEL_ADDR, 8'h00);
         req(4'h9, SPD_CS_THR_HIGH_ADDR, 8'h00);
         req(4'h9, SPD_XIRQ_EN1_ADDR, 8'h00);
         req(4'ha, SPD_CRC_SECT_CNT_ADDR, 8'h3c);
      end
      @(negedge i_sys_clk);
      chk_rd("page select", page, o_page_sel);
      $display("test page decode done");
      req(4'he, 8'h8b, 8'h01);
      @(negedge i_sys_clk);
      chk_rd("busy", 8'h01, {7'h00, o_busy});
      req(4'hd, 8'h8b, 8'h00);
      req(4'he, 8'h13, 8'h00);
      req(4'ha, 8'h10, 8'h5c);
      req(4'h9, 8'h10, 8'h00);
      req(4'h1, 8'h97, 8'h00);
      $display("test bit and memory done");
      // Let frozen results drain before reset throws them away
      req(4'h8, 8'h00, 8'h00);
      req(4'h8, 8'h00, 8'h00);
      i_reset <= 1'h1;
      repeat (2) @(posedge i_sys_clk);
      i_reset <= 1'h0;
      page = SPD_PAGE_SEL_RESET;
      req(4'h9, SPD_PAGE_SEL_ADDR, 8'h00);
      $display("test mid-run reset done");
      for (int i = 0; i < 400; i++)
      begin
         seed = xs(seed);
         req({|seed[6:4], seed[7] & seed[2], seed[1:0]}, seed[12:10] == 3'h0 ? SPD_PAGE_SEL_ADDR : seed[23:16],
            seed[9:8] == 2'h3 ? seed[31:24] : {4'h0, {4{seed[8]}}});
      end
      repeat (4) req(4'h8, 8'h00, 8'h00);
      $display("test random done");
      chk_st("pending", 22'h0, 22'(q_rd.size() + q_st.size()));
      report_and_stop();
   end
endmodule
